// ==== inc/msmac_pkg.sv ====
// Purpose : Shared constants and types for the multiply-subtract datapath
// Assumes : Single clock, one-cycle execution per issued operation
// Notes   : Opcode bytes and field positions are held here once
package msmac_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned MSMAC_ACC_W  = 40;   // Accumulator width
  localparam int unsigned MSMAC_OPD_W  = 16;   // Memory / temp operand width
  localparam int unsigned MSMAC_EXT_W  = 17;   // Extended multiplier input width
  localparam int unsigned MSMAC_PRD_W  = 32;   // Multiplier result width
  localparam int unsigned MSMAC_NACC   = 4;    // Number of accumulators
  localparam int unsigned MSMAC_IDX_W  = 2;    // Accumulator index width

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MSMAC_AHI_MSB = 32;  // Accumulator high slice top
  localparam int unsigned MSMAC_AHI_LSB = 16;  // Accumulator high slice bottom
  localparam int unsigned MSMAC_RND_BIT = 15;  // Rounding weight position
  localparam int unsigned MSMAC_NARROW_MSB = 31; // Sign bit for 32-bit overflow

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam logic [7:0]  MSMAC_COEF_OP_BYTE = 8'hd1;   // Coefficient form first byte
  localparam logic [1:0]  MSMAC_COEF_TAIL    = 2'h2;    // Coefficient form fixed bits
  localparam logic [39:0] MSMAC_ACC_RST      = 40'h00_0000_0000; // Accumulator reset
  localparam logic [39:0] MSMAC_RND_ADD      = 40'h00_0000_8000; // Rounding addend
  localparam logic [39:0] MSMAC_POS40        = 40'h7f_ffff_ffff; // 40-bit maximum
  localparam logic [39:0] MSMAC_NEG40        = 40'h80_0000_0000; // 40-bit minimum
  localparam logic [39:0] MSMAC_POS32        = 40'h00_7fff_ffff; // 32-bit maximum
  localparam logic [39:0] MSMAC_NEG32        = 40'hff_8000_0000; // 32-bit minimum
  localparam logic [31:0] MSMAC_PRD_SAT      = 32'h7fff_ffff;    // Product clamp
  localparam logic [31:0] MSMAC_PRD_OVF      = 32'h8000_0000;    // Overflowing product
  localparam int unsigned MSMAC_CYCLES       = 1;   // Execution latency in cycles

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Operation forms
  typedef enum logic [4:0] {
    MSMAC_FORM_REG  = 5'b00001,   // Accumulator high times temporary
    MSMAC_FORM_COEF = 5'b00010,   // Memory times coefficient, signed
    MSMAC_FORM_UCOF = 5'b00100,   // Memory times coefficient, unsigned coef
    MSMAC_FORM_DUAL = 5'b01000,   // Two data memory operands
    MSMAC_FORM_MEMT = 5'b10000    // Memory times temporary
  } msmac_form_t;

  // Mode bits presented by the status registers
  typedef struct packed {
    logic fractional_mode;
    logic multiply_saturation_mode;
    logic rounding_method;
    logic wide_overflow_mode;
    logic result_saturation_mode;
    logic sign_extension_mode;
    logic legacy_compat_mode;
  } msmac_mode_t;

  // One issued operation
  typedef struct packed {
    msmac_form_t                form;
    logic                       round_req;    // Rounding option present
    logic                       force_wide;   // Local 40-bit overflow option
    logic                       copy_t3;      // Copy memory operand to T3
    logic                       has_src;      // Optional source accumulator given
    logic [MSMAC_IDX_W-1:0]     src_idx;
    logic [MSMAC_IDX_W-1:0]     dst_idx;
    logic                       x_uns;        // Unsigned qualifier, first operand
    logic                       y_uns;        // Unsigned qualifier, second operand
    logic [MSMAC_OPD_W-1:0]     temp;         // Temporary register value
    logic [MSMAC_OPD_W-1:0]     mem_x;        // Single / first memory operand
    logic [MSMAC_OPD_W-1:0]     mem_y;        // Coefficient or second operand
  } msmac_op_t;

endpackage : msmac_pkg

// ==== hdl/msmac_ext17.sv ====
// Purpose : Extends a 16-bit operand to the 17-bit multiplier input
// Assumes : Purely combinational
// Notes   : Zero extension when i_signed is low (unsigned, or sign extension off in the dual form)
module msmac_ext17 (
  input  wire logic [15:0] i_val,       // Operand
  input  wire logic        i_signed,    // High to sign-extend
  output logic      [16:0] o_ext        // Extended operand
);
  import msmac_pkg::*;

  // Copy the top bit only when signed
  assign o_ext = {i_signed & i_val[MSMAC_OPD_W-1], i_val};

endmodule // msmac_ext17

// ==== hdl/msmac_core.sv ====
// Purpose : Multiply-and-subtract datapath with accumulators and flags
// Assumes : Decoder presents a decoded op and valid for one cycle each
// Notes   : Results and flags land one clock after the issue
//
// How it works
// [RQ1] Register form: acc bits 32..16 times temp
// [RQ2] Fractional mode doubles the product
// [RQ3] Product overflow handled per multiply saturation mode
// [RQ4] Product sign-extended to 40 bits, subtracted
// [RQ5] Round by method only when option present
// [RQ6] Overflow width from wide mode; sets flag
// [RQ7] Saturate destination on overflow when enabled
// [RQ8] Coefficient form: memory times coefficient, signed
// [RQ9] Optionally copy memory operand to T3
// [RQ10] Software keeps coefficients in internal memory
// [RQ11] Legacy mode with narrow overflow stays compatible
// [RQ12] Decoder recognises coefficient form encoding
// [RQ13] One-cycle execution; register form pairable
// [RQ14] Dual memory form, optional forced wide mode
// [RQ15] Unsigned coefficient form zero-extends coefficient
// [RQ16] Unsigned qualifier zero-extends, else per mode
// [RQ17] Missing source uses destination as minuend
module msmac_core (
  input  wire logic                 i_clk_sys,     // System clock, 200 MHz
  input  wire logic                 i_sys_rst,     // Async reset, active high
  input  wire logic                 i_valid,       // Operation issued this cycle
  input  wire msmac_pkg::msmac_op_t i_op,          // Decoded operation
  input  wire msmac_pkg::msmac_mode_t i_mode,      // Status mode bits
  input  wire logic [23:0]          i_instr,       // Raw three-byte instruction
  input  wire logic                 i_ovf_clr,     // Clear all overflow flags
  output logic [159:0]              o_acc,         // Accumulators 3..0 packed
  output logic [3:0]                o_ovf_flag,    // Per-accumulator overflow flags
  output logic [15:0]               o_t3,          // Third temporary register
  output logic                      o_t3_wr,       // Pulse: T3 was written
  output logic                      o_done,        // Pulse: result written
  output logic                      o_coef_form    // Raw word is coefficient form
);
  import msmac_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [MSMAC_ACC_W-1:0] acc_q [MSMAC_NACC];     // Accumulators
  logic [MSMAC_ACC_W-1:0] acc_d [MSMAC_NACC];
  logic [MSMAC_NACC-1:0]  ovf_q, ovf_d;            // Overflow flags
  logic [MSMAC_OPD_W-1:0] t3_q, t3_d;              // Third temporary register
  logic                   t3_wr_q, t3_wr_d;        // T3 write pulse
  logic                   done_q, done_d;          // Completion pulse
  logic                   coef_q, coef_d;          // Coefficient form match

  // ----------------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------------
  logic [MSMAC_OPD_W-1:0] a_raw, b_raw;            // Multiplier inputs, raw
  logic                   a_sgn, b_sgn;            // Sign-extend selects
  logic [MSMAC_EXT_W-1:0] a_ext, b_ext;            // 17-bit multiplier inputs
  logic [MSMAC_ACC_W-1:0] src_acc;                 // Selected source accumulator
  logic [MSMAC_ACC_W-1:0] hi_acc;                  // Accumulator for the register form

  // Pick operands for each form
  always_comb begin
    hi_acc = acc_q[i_op.src_idx];
    a_raw  = i_op.mem_x;
    b_raw  = i_op.mem_y;
    a_sgn  = 1'b1;
    b_sgn  = 1'b1;
    case (i_op.form)
      MSMAC_FORM_REG: begin
        a_raw = hi_acc[MSMAC_AHI_MSB-1:MSMAC_AHI_LSB]; // RQ1
        b_raw = i_op.temp;
      end
      MSMAC_FORM_COEF: begin
        b_raw = i_op.mem_y;                             // RQ8
      end
      MSMAC_FORM_UCOF: begin
        b_sgn = 1'b0;                                   // RQ15
      end
      MSMAC_FORM_DUAL: begin
        a_sgn = ~i_op.x_uns & i_mode.sign_extension_mode; // RQ16
        b_sgn = ~i_op.y_uns & i_mode.sign_extension_mode; // RQ16
      end
      MSMAC_FORM_MEMT: begin
        b_raw = i_op.temp;
      end
      default: begin
        a_raw = i_op.mem_x;
      end
    endcase
  end

  // Extenders for the two multiplier inputs
  msmac_ext17 u_ext_a (
    .i_val    (a_raw),
    .i_signed (a_sgn),
    .o_ext    (a_ext)
  );

  msmac_ext17 u_ext_b (
    .i_val    (b_raw),
    .i_signed (b_sgn),
    .o_ext    (b_ext)
  );

  // ----------------------------------------------------------------------
  // Multiply, scale and extend
  // ----------------------------------------------------------------------
  logic signed [33:0]     prod_full;               // 17x17 signed product
  logic signed [34:0]     prod_frac;               // After optional doubling
  logic [MSMAC_PRD_W-1:0] prod32;                  // 32-bit multiplier result
  logic [MSMAC_ACC_W-1:0] prod40;                  // Sign-extended product
  logic                   prod_ovf_case;           // Fractional -1 * -1 case
  logic                   a_hi_bit;                // Register-form slice top bit

  // Product, fractional shift and saturation of the special case
  always_comb begin
    a_hi_bit  = hi_acc[MSMAC_AHI_MSB];
    prod_full = $signed(i_op.form == MSMAC_FORM_REG ? {a_hi_bit, a_raw} : a_ext)
              * $signed(b_ext);
    prod_frac = i_mode.fractional_mode ? {prod_full, 1'b0}          // RQ2
                                       : {prod_full[33], prod_full};
    prod32    = prod_frac[MSMAC_PRD_W-1:0];
    // Doubled 8000h*8000h overflows 32 bits
    prod_ovf_case = i_mode.fractional_mode && (prod32 == MSMAC_PRD_OVF)
                  && !prod_frac[34];
    if (prod_ovf_case && i_mode.multiply_saturation_mode) begin
      prod32 = MSMAC_PRD_SAT;                                       // RQ3
    end
    prod40 = {{(MSMAC_ACC_W-MSMAC_PRD_W){prod32[MSMAC_PRD_W-1]}}, prod32}; // RQ4
  end

  // ----------------------------------------------------------------------
  // Subtract, round, detect overflow, saturate
  // ----------------------------------------------------------------------
  logic [MSMAC_ACC_W:0]   diff41;                  // Difference with carry bit
  logic [MSMAC_ACC_W:0]   rnd41;                   // After rounding
  logic [MSMAC_ACC_W-1:0] res;                     // Final result
  logic                   wide_eff;                // Effective wide overflow mode
  logic                   ovf40, ovf32, ovf;       // Overflow detection
  logic                   neg;                     // Direction of overflow

  // Arithmetic path
  always_comb begin
    src_acc  = i_op.has_src ? acc_q[i_op.src_idx] : acc_q[i_op.dst_idx]; // RQ17
    wide_eff = i_mode.wide_overflow_mode                               // RQ6
             | (i_op.force_wide & (i_op.form == MSMAC_FORM_DUAL));     // RQ14
    diff41   = {src_acc[MSMAC_ACC_W-1], src_acc}
             - {prod40[MSMAC_ACC_W-1], prod40};                        // RQ4
    rnd41    = diff41;
    if (i_op.round_req) begin                                          // RQ5
      rnd41 = diff41 + {1'b0, MSMAC_RND_ADD};
      if (!i_mode.rounding_method) begin
        rnd41[MSMAC_RND_BIT:0] = '0;
      end else if (diff41[MSMAC_RND_BIT:0] == 16'h8000 && !diff41[MSMAC_AHI_LSB]) begin
        rnd41 = diff41;                                                // Tie to even
        rnd41[MSMAC_RND_BIT:0] = '0;
      end else begin
        rnd41[MSMAC_RND_BIT:0] = '0;
      end
    end
    neg   = rnd41[MSMAC_ACC_W];
    ovf40 = rnd41[MSMAC_ACC_W] ^ rnd41[MSMAC_ACC_W-1];                 // RQ6
    // Narrow mode watches bit 31; legacy compatible by construction
    ovf32 = (rnd41[MSMAC_ACC_W:MSMAC_NARROW_MSB] != '0)
          && (rnd41[MSMAC_ACC_W:MSMAC_NARROW_MSB] != '1);              // RQ11
    ovf   = wide_eff ? ovf40 : ovf32;                                  // RQ6
    res   = rnd41[MSMAC_ACC_W-1:0];
    if (ovf && i_mode.result_saturation_mode) begin                    // RQ7
      if (wide_eff) begin
        res = neg ? MSMAC_NEG40 : MSMAC_POS40;
      end else begin
        res = neg ? MSMAC_NEG32 : MSMAC_POS32;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Writes result, flag and T3 in the one execution cycle
  always_comb begin
    for (int k = 0; k < MSMAC_NACC; k++) begin
      acc_d[k] = acc_q[k];
    end
    ovf_d   = ovf_q;
    t3_d    = t3_q;
    t3_wr_d = 1'b0;
    done_d  = 1'b0;
    // Raw encoding check: pattern byte, then fixed tail bits
    coef_d  = (i_instr[23:16] == MSMAC_COEF_OP_BYTE)
            && (i_instr[3:2] == MSMAC_COEF_TAIL);                      // RQ12
    if (i_ovf_clr) begin
      ovf_d = '0;                                    // Clear first, set wins below
    end
    if (i_valid) begin                               // RQ13
      acc_d[i_op.dst_idx] = res;
      done_d              = 1'b1;
      if (ovf) begin
        ovf_d[i_op.dst_idx] = 1'b1;                  // RQ6
      end
      if (i_op.copy_t3 && i_op.form != MSMAC_FORM_REG) begin
        t3_d    = i_op.mem_x;                        // RQ9
        t3_wr_d = 1'b1;
      end
    end
  end

  // Register all state
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < MSMAC_NACC; k++) begin
        acc_q[k] <= MSMAC_ACC_RST;
      end
      ovf_q   <= '0;
      t3_q    <= '0;
      t3_wr_q <= 1'b0;
      done_q  <= 1'b0;
      coef_q  <= 1'b0;
    end else begin
      for (int k = 0; k < MSMAC_NACC; k++) begin
        acc_q[k] <= acc_d[k];
      end
      ovf_q   <= ovf_d;
      t3_q    <= t3_d;
      t3_wr_q <= t3_wr_d;
      done_q  <= done_d;
      coef_q  <= coef_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_acc       = {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
  assign o_ovf_flag  = ovf_q;
  assign o_t3        = t3_q;
  assign o_t3_wr     = t3_wr_q;
  assign o_done      = done_q;
  assign o_coef_form = coef_q;

endmodule // msmac_core

// ==== sim/msmac_core_properties.sv ====
// Purpose : Port-level properties of the multiply-subtract datapath
// Assumes : One clock, asynchronous active-high reset
// Notes   : Bound to every instance of the core
module msmac_core_properties (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_valid,
  input  wire msmac_pkg::msmac_op_t i_op,
  input  wire logic [23:0]          i_instr,
  input  wire logic                 i_ovf_clr,
  input  wire logic [159:0]         o_acc,
  input  wire logic [3:0]           o_ovf_flag,
  input  wire logic [15:0]          o_t3,
  input  wire logic                 o_t3_wr,
  input  wire logic                 o_done,
  input  wire logic                 o_coef_form
);
  timeunit 1ns;
  timeprecision 1ps;
  import msmac_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------------
  // Issue and completion
  // ----------------------------------------------------------------------
  sequence s_lone; i_valid ##1 !i_valid; endsequence
  property p_issue_done; i_valid |=> o_done; endproperty
  a_issue_done: assert property (p_issue_done) else $error("no done after issue");
  property p_lone_done; s_lone |=> !o_done; endproperty
  a_lone_done: assert property (p_lone_done) else $error("done longer than one cycle");
  property p_acc_hold; !i_valid |=> $stable(o_acc); endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved while idle");
  // ----------------------------------------------------------------------
  // Temporary copy, decode and flags
  // ----------------------------------------------------------------------
  property p_t3_copy;
    i_valid && i_op.copy_t3 && i_op.form != MSMAC_FORM_REG |=> o_t3_wr && o_t3 == $past(i_op.mem_x);
  endproperty
  a_t3_copy: assert property (p_t3_copy) else $error("memory operand not copied");
  property p_t3_hold; !i_valid |=> !o_t3_wr && $stable(o_t3); endproperty
  a_t3_hold: assert property (p_t3_hold) else $error("temporary written while idle");
  property p_coef;
    1'h1 |=> o_coef_form == ($past(i_instr[23:16]) == MSMAC_COEF_OP_BYTE
                             && $past(i_instr[3:2]) == MSMAC_COEF_TAIL);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient form decode wrong");
  property p_flag_clr; i_ovf_clr && !i_valid |=> o_ovf_flag == 4'h0; endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");
  property p_flag_keep;
    !i_ovf_clr |=> (o_ovf_flag & $past(o_ovf_flag)) == $past(o_ovf_flag);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag dropped without clear");
endmodule // msmac_core_properties
bind msmac_core msmac_core_properties u_msmac_core_properties (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_op(i_op),
  .i_instr(i_instr), .i_ovf_clr(i_ovf_clr), .o_acc(o_acc), .o_ovf_flag(o_ovf_flag),
  .o_t3(o_t3), .o_t3_wr(o_t3_wr), .o_done(o_done), .o_coef_form(o_coef_form));

// ==== sim/msmac_issue_model.sv ====
// Purpose : Decoder-side model that issues operations to the datapath
// Assumes : Each op is shown for one taking edge, launched on a falling edge
// Notes   : A released operand bus shows inverted data, never stale values
module msmac_issue_model (
  input  wire logic                 i_clk_sys,  // System clock
  output logic                      o_valid,    // Op issued
  output msmac_pkg::msmac_op_t      o_op        // Decoded op
);
  timeunit 1ns;
  timeprecision 1ps;
  import msmac_pkg::*;
  initial begin
    o_valid = 1'h0;
    o_op    = '0;
  end
  // Coefficient words are taken from on-chip storage only
  task automatic issue(input msmac_op_t op);
    @(negedge i_clk_sys);
    o_valid = 1'h1;
    o_op    = op;
    @(negedge i_clk_sys);
    o_valid = 1'h0;
    o_op    = ~op;
  endtask
endmodule // msmac_issue_model

// ==== sim/tb_msmac_core.sv ====
// Purpose : Self-checking bench for the multiply-subtract datapath
// Assumes : Inputs change on falling edges; shadow model predicts results
// Notes   : At least one idle cycle separates issued ops
module tb_msmac_core;
  timeunit 1ns;
  timeprecision 1ps;
  import msmac_pkg::*;
  logic         clk = 1'h0;
  logic         rst = 1'h1;
  logic         ovf_clr = 1'h0;
  logic [23:0]  instr = 24'h00_0000;
  msmac_mode_t  mode = '0;
  msmac_op_t    op, d_op;
  logic         d_valid;
  logic [159:0] acc_o;
  logic [3:0]   flag_o;
  logic [15:0]  t3_o;
  logic         t3_wr, done, coef;
  logic [39:0]  acc [4] = '{default: '0};
  logic [3:0]   flg = 4'h0;
  logic [15:0]  t3 = 16'h0000;
  int           bad_count = 0;
  int           check_count = 0;
  always #2.5 clk = ~clk;
  msmac_issue_model u_msmac_issue_model (.i_clk_sys(clk), .o_valid(d_valid), .o_op(d_op));
  msmac_core u_msmac_core (.i_clk_sys(clk), .i_sys_rst(rst), .i_valid(d_valid), .i_op(d_op),
    .i_mode(mode), .i_instr(instr), .i_ovf_clr(ovf_clr), .o_acc(acc_o), .o_ovf_flag(flag_o),
    .o_t3(t3_o), .o_t3_wr(t3_wr), .o_done(done), .o_coef_form(coef));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Reference result: {overflow, accumulator}
  function automatic logic [40:0] ref_mas(input msmac_op_t p);
    logic [16:0] x, y;
    logic [33:0] pp;
    logic [31:0] pr;
    logic [40:0] r;
    logic [39:0] mn;
    logic        wd, ov;
    x = {p.mem_x[15], p.mem_x};
    y = {p.temp[15], p.temp};
    if (p.form == MSMAC_FORM_REG) x = acc[p.src_idx][32:16];
    if (p.form inside {MSMAC_FORM_COEF, MSMAC_FORM_UCOF})
      y = {p.mem_y[15] & (p.form == MSMAC_FORM_COEF), p.mem_y};
    if (p.form == MSMAC_FORM_DUAL) begin
      x = {p.mem_x[15] & !p.x_uns & mode.sign_extension_mode, p.mem_x};
      y = {p.mem_y[15] & !p.y_uns & mode.sign_extension_mode, p.mem_y};
    end
    pp = $signed(x) * $signed(y);
    pr = pp[31:0] << mode.fractional_mode;
    if (mode.fractional_mode && mode.multiply_saturation_mode && pr == MSMAC_PRD_OVF && !pp[33])
      pr = MSMAC_PRD_SAT;
    mn = p.has_src ? acc[p.src_idx] : acc[p.dst_idx];
    r = {mn[39], mn} - {{9{pr[31]}}, pr};
    if (p.round_req) begin
      if (!(mode.rounding_method && r[16:0] == 17'h0_8000)) r = r + 41'h000_0000_8000;
      r[15:0] = 16'h0000;
    end
    wd = mode.wide_overflow_mode | (p.force_wide & p.form == MSMAC_FORM_DUAL);
    ov = wd ? r[40] != r[39] : r[40:31] != {10{r[40]}};
    if (ov && mode.result_saturation_mode)
      r[39:0] = wd ? (r[40] ? MSMAC_NEG40 : MSMAC_POS40) : (r[40] ? MSMAC_NEG32 : MSMAC_POS32);
    return {ov, r[39:0]};
  endfunction
  // Issue one op, update the shadow state, compare every output except o_coef_form
  task automatic run(input msmac_op_t p);
    logic [40:0] e;
    e = ref_mas(p);
    u_msmac_issue_model.issue(p);
    acc[p.dst_idx] = e[39:0];
    flg[p.dst_idx] |= e[40];
    if (p.copy_t3 && p.form != MSMAC_FORM_REG) t3 = p.mem_x;
    chk(done === 1'h1 && t3_wr === (p.copy_t3 && p.form != MSMAC_FORM_REG), "done pulse");
    chk(acc_o === {acc[3], acc[2], acc[1], acc[0]} && flag_o === flg && t3_o === t3,
        "result");
  endtask
  task automatic t_round;
    for (int i = 0; i < 3; i++) begin
      op = '{form: MSMAC_FORM_MEMT, dst_idx: 2'h3, mem_x: 16'h0001, temp: 16'h8000, default: '0};
      mode.rounding_method = (i == 0);
      op.round_req = (i < 2);
      run(op);
    end
  endtask
  task automatic t_regs;
    op = '{form: MSMAC_FORM_MEMT, mem_x: 16'h7fff, temp: 16'h8000, copy_t3: 1'h1, default: '0};
    run(op);
    op = '{form: MSMAC_FORM_REG, dst_idx: 2'h1, temp: 16'h2000, copy_t3: 1'h1, default: '0};
    mode.fractional_mode = 1'h1;
    run(op);
    op.has_src = 1'h1;
    op.dst_idx = 2'h2;
    mode.fractional_mode = 1'h0;
    run(op);
  endtask
  task automatic t_coef;
    logic [23:0] w [3] = '{24'hd1_0008, 24'hd1_0004, 24'hd2_0008};
    op = '{form: MSMAC_FORM_COEF, dst_idx: 2'h1, mem_x: 16'h1234, mem_y: 16'hffff, default: '0};
    op.copy_t3 = 1'h1;
    run(op);
    op.form = MSMAC_FORM_UCOF;
    run(op);
    for (int i = 0; i < 3; i++) begin
      instr = w[i];
      @(negedge clk);
      chk(coef === (i == 0), "coefficient decode");
    end
  endtask
  task automatic t_dual;
    mode.result_saturation_mode = 1'h1;
    for (int i = 0; i < 8; i++) begin
      op = '{form: MSMAC_FORM_DUAL, dst_idx: 2'h2, mem_x: 16'h8000, mem_y: 16'h8000, default: '0};
      {op.x_uns, op.y_uns, mode.sign_extension_mode} = 3'(i);
      op.force_wide = i[0];
      run(op);
    end
  endtask
  task automatic t_ovf;
    for (int i = 0; i < 16; i++) begin
      op = '{form: MSMAC_FORM_MEMT, mem_x: 16'h8000, temp: 16'h8000, default: '0};
      mode = '0;
      mode.fractional_mode = 1'h1;
      {mode.legacy_compat_mode, mode.multiply_saturation_mode} = 2'(i >> 2);
      {mode.result_saturation_mode, mode.wide_overflow_mode} = 2'(i);
      run(op);
    end
    // Clear and a new overflow meet in one cycle: the set must win
    mode.wide_overflow_mode = 1'h0;
    op.force_wide = 1'h1;
    ovf_clr = 1'h1;
    flg = 4'h0;
    run(op);
    ovf_clr = 1'h1;
    @(negedge clk);
    ovf_clr = 1'h0;
    flg = 4'h0;
    chk(flag_o === 4'h0, "flag clear");
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    chk(acc_o === 160'h0 && flag_o === 4'h0 && t3_o === 16'h0000, "reset state");
    t_round;
    t_regs;
    t_coef;
    t_dual;
    t_ovf;
    test_done;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule // tb_msmac_core
